// [frame_overflow_event_reporter.sv]
// Per-frame overflow classifier, event packet builder and register slave
//
// How it works
// - Classify each frame; event per kind, filtered
// - Event carries kind, frame number, timestamp
// - Event packet is one 64-bit word
// - Packet bits 15:0 hold frame number
// - Packet bits 47:32 hold overflow mask
// - Frame number taken from camera stream
// - Frame number is 16-bit, wraps to zero
// - Truncated frame data still forwarded to DMA
// - Lost frame fully discarded, no DMA
// - Truncated and lost never both set
// - Event decodes to number plus three flags
// - Eight filter settings, reset incomplete-or-lost
// - Above enter level, cut frame as incomplete
// - In overflow drop frames; exit below level
`include "overflow_event_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module frame_overflow_event_reporter (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire overflow_event_pkg::avs_req_s  avs_req,
  output var  overflow_event_pkg::avs_rsp_s  avs_rsp,
  input  wire overflow_event_pkg::cam_s      cam,
  input  wire logic [7:0]                    buffer_occupancy,
  output var  overflow_event_pkg::dma_s      dma_out,
  output var  overflow_event_pkg::event_s    event_out,
  input  wire logic                          event_ready,
  output logic                               overflow_active,
  output logic                               irq
);
  import overflow_event_pkg::*;

  state_s state_reg;
  state_s state_next;

  // ****************************************************************
  // Combinational helpers
  // ****************************************************************
  logic        ovf_now;
  logic        ovf_rise;
  logic        end_seen;
  logic        kind_trunc;
  logic        kind_drop;
  logic        kind_intact;
  logic        selected;
  logic [15:0] mask_word;
  logic [63:0] packet;
  logic        slot_free;
  logic        bus_req;
  logic        bus_take;
  logic        wr_take;
  logic [31:0] rd_word;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;

  always_comb begin
    state_next = state_reg;
    ovf_now = state_reg.overflow;
    ovf_rise = 1'b0;
    end_seen = 1'b0;
    kind_trunc = 1'b0;
    kind_drop = 1'b0;
    kind_intact = 1'b0;
    selected = 1'b0;
    mask_word = 16'h0000;
    packet = 64'h0000_0000_0000_0000;
    slot_free = 1'b0;
    bus_req = 1'b0;
    bus_take = 1'b0;
    wr_take = 1'b0;
    rd_word = 32'h0000_0000;
    irq_set = 3'h0;
    irq_clr = 3'h0;

    // ****************************************************************
    // Overflow state with hysteresis
    // ****************************************************************
    // Strict compares, so a level sitting on a threshold changes nothing
    // Half percent steps; the finest trip point is one step
    if (!state_reg.overflow &&
        (buffer_occupancy > state_reg.enter_level)) begin
      ovf_now = 1'b1;
    end else if (state_reg.overflow &&
                 (buffer_occupancy < state_reg.exit_level)) begin
      ovf_now = 1'b0;
    end
    ovf_rise = ovf_now && !state_reg.overflow;
    state_next.overflow = ovf_now;

    // ****************************************************************
    // Frame timestamp
    // ****************************************************************
    // Free running; wraps after about 17 s at 250 MHz
    state_next.stamp_count = state_reg.stamp_count + 32'h0000_0001;

    // ****************************************************************
    // Frame tracking and data gate
    // ****************************************************************
    state_next.dma.valid = 1'b0;
    state_next.dma.last = 1'b0;
    state_next.dma.truncated = 1'b0;

    case (state_reg.frame)
      FR_IDLE: begin
        if (cam.frame_start) begin
          state_next.frame_number = cam.frame_number;
          state_next.frame_stamp = state_reg.stamp_count;
          // Decision is made on the start cycle, using the fresh state
          state_next.frame = ovf_now ? FR_DROP : FR_PASS;
        end
      end
      FR_PASS: begin
        if (ovf_now) begin
          // Cut at once; the beat of this cycle is not forwarded
          state_next.frame = FR_CUT;
          if (cam.frame_end) begin
            state_next.frame = FR_IDLE;
            end_seen = 1'b1;
            kind_trunc = 1'b1;
          end
        end else begin
          if (cam.data_valid) begin
            state_next.dma.valid = 1'b1;
            state_next.dma.data = cam.data;
          end
          if (cam.frame_end) begin
            state_next.frame = FR_IDLE;
            end_seen = 1'b1;
            kind_intact = 1'b1;
            state_next.dma.valid = 1'b1;
            state_next.dma.last = 1'b1;
            if (!cam.data_valid) begin
              state_next.dma.data = 32'h0000_0000;
            end
          end
        end
        if (ovf_now) begin
          // Closing beat so the host sees the short frame end
          state_next.dma.valid = 1'b1;
          state_next.dma.last = 1'b1;
          state_next.dma.truncated = 1'b1;
          state_next.dma.data = 32'h0000_0000;
        end
      end
      FR_CUT: begin
        if (cam.frame_end) begin
          state_next.frame = FR_IDLE;
          end_seen = 1'b1;
          kind_trunc = 1'b1;
        end
      end
      FR_DROP: begin
        // Nothing of this frame reaches the DMA side
        if (cam.frame_end) begin
          state_next.frame = FR_IDLE;
          end_seen = 1'b1;
          kind_drop = 1'b1;
        end
      end
      default: begin
        state_next.frame = FR_IDLE;
      end
    endcase

    // ****************************************************************
    // Event filter and packet
    // ****************************************************************
    case (state_reg.filter)
      FILTER_INCOMPLETE: begin
        selected = kind_trunc;
      end
      FILTER_DROPPED: begin
        selected = kind_drop;
      end
      FILTER_INCOMPLETE_OR_DROPPED: begin
        selected = kind_trunc || kind_drop;
      end
      FILTER_CORRECT: begin
        selected = kind_intact;
      end
      FILTER_INCOMPLETE_OR_CORRECT: begin
        selected = kind_trunc || kind_intact;
      end
      FILTER_DROPPED_OR_CORRECT: begin
        selected = kind_drop || kind_intact;
      end
      FILTER_ALL: begin
        selected = end_seen;
      end
      default: begin
        // Unused code: no events rather than guessing
        selected = 1'b0;
      end
    endcase

    // ****************************************************************
    // Packet
    // ****************************************************************
    // Kinds come from one frame state, so only one can be set
    mask_word[`MASK_TRUNC_BIT] = kind_trunc;
    mask_word[`MASK_DROP_BIT] = kind_drop;
    mask_word[`MASK_INTACT_BIT] = kind_intact;
    packet[`PKT_FRAME_MSB:`PKT_FRAME_LSB] = state_reg.frame_number;
    packet[`PKT_MASK_MSB:`PKT_MASK_LSB] = mask_word;

    // ****************************************************************
    // Event slot
    // ****************************************************************
    // One slot only: a slow host loses events, frames never stall
    slot_free = !state_reg.event_out.valid || event_ready;
    if (state_reg.event_out.valid && event_ready) begin
      state_next.event_out.valid = 1'b0;
    end
    if (selected) begin
      if (slot_free) begin
        state_next.event_out.valid = 1'b1;
        state_next.event_out.data = packet;
        state_next.event_out.stamp = state_reg.frame_stamp;
        state_next.last_packet = packet;
        irq_set[`IRQ_EVENT_BIT] = 1'b1;
      end else begin
        // Host too slow: this event is lost, flagged to software
        irq_set[`IRQ_OVERRUN_BIT] = 1'b1;
      end
    end
    irq_set[`IRQ_OVERFLOW_BIT] = ovf_rise;

    // ****************************************************************
    // Avalon-MM slave, one wait cycle per access
    // ****************************************************************
    // Fixed single wait cycle; masters still poll waitrequest
    bus_req = avs_req.read || avs_req.write;
    bus_take = bus_req && !state_reg.rsp.waitrequest;
    wr_take = bus_take && avs_req.write;
    state_next.rsp.waitrequest = !(bus_req && state_reg.rsp.waitrequest);

    // ****************************************************************
    // Register read
    // ****************************************************************
    // Mux follows the address; data is latched only in the wait cycle
    case (avs_req.address)
      `OFS_CTRL: begin
        rd_word[`CTRL_FILTER_MSB:`CTRL_FILTER_LSB] = state_reg.filter;
      end
      `OFS_ENTER_LEVEL: begin
        rd_word[7:0] = state_reg.enter_level;
      end
      `OFS_EXIT_LEVEL: begin
        rd_word[7:0] = state_reg.exit_level;
      end
      `OFS_STATE: begin
        rd_word[0] = state_reg.overflow;
        rd_word[2:1] = state_reg.frame;
        rd_word[3] = state_reg.event_out.valid;
      end
      `OFS_IRQ_STATUS: begin
        rd_word[2:0] = state_reg.irq_status;
      end
      `OFS_IRQ_MASK: begin
        rd_word[2:0] = state_reg.irq_mask;
      end
      `OFS_LAST_LO: begin
        rd_word = state_reg.last_packet[31:0];
      end
      `OFS_LAST_HI: begin
        rd_word = state_reg.last_packet[63:32];
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    if (bus_req && state_reg.rsp.waitrequest) begin
      state_next.rsp.readdata = avs_req.read ? rd_word : 32'h0000_0000;
    end

    // ****************************************************************
    // Register write
    // ****************************************************************
    // Writes land on the taking edge only, never in the wait cycle
    if (wr_take) begin
      case (avs_req.address)
        `OFS_CTRL: begin
          state_next.filter = filter_e'(
            avs_req.writedata[`CTRL_FILTER_MSB:`CTRL_FILTER_LSB]);
        end
        `OFS_ENTER_LEVEL: begin
          state_next.enter_level = avs_req.writedata[7:0];
        end
        `OFS_EXIT_LEVEL: begin
          state_next.exit_level = avs_req.writedata[7:0];
        end
        `OFS_IRQ_STATUS: begin
          irq_clr = avs_req.writedata[2:0];
        end
        `OFS_IRQ_MASK: begin
          state_next.irq_mask = avs_req.writedata[2:0];
        end
        default: begin
          state_next.irq_mask = state_reg.irq_mask;
        end
      endcase
    end

    // ****************************************************************
    // Interrupt
    // ****************************************************************
    // Set wins over a clear in the same cycle
    // Level output; software clears the cause, not the line
    state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.filter <= filter_e'(`FILTER_RESET);
      state_reg.enter_level <= `ENTER_LEVEL_RESET;
      state_reg.exit_level <= `EXIT_LEVEL_RESET;
      state_reg.frame <= FR_IDLE;
      state_reg.rsp.waitrequest <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_rsp = state_reg.rsp;
  assign dma_out = state_reg.dma;
  assign event_out = state_reg.event_out;
  assign overflow_active = state_reg.overflow;
  assign irq = state_reg.irq;

endmodule

`default_nettype wire

// [overflow_event_defines.svh]
// Offsets, field positions, reset values and counts of the overflow event block
`ifndef OVERFLOW_EVENT_DEFINES_SVH
`define OVERFLOW_EVENT_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL        5'h00
`define OFS_ENTER_LEVEL 5'h04
`define OFS_EXIT_LEVEL  5'h08
`define OFS_STATE       5'h0c
`define OFS_IRQ_STATUS  5'h10
`define OFS_IRQ_MASK    5'h14
`define OFS_LAST_LO     5'h18
`define OFS_LAST_HI     5'h1c

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define CTRL_FILTER_LSB   0
`define CTRL_FILTER_MSB   2
`define FILTER_RESET      3'h2
// Occupancy in half percent steps, 0 to 200
`define ENTER_LEVEL_RESET 8'hc7
`define EXIT_LEVEL_RESET  8'h64

// ****************************************************************
// Packet layout
// ****************************************************************
`define PKT_FRAME_LSB     0
`define PKT_FRAME_MSB     15
`define PKT_MASK_LSB      32
`define PKT_MASK_MSB      47
`define MASK_TRUNC_BIT    0
`define MASK_DROP_BIT     1
`define MASK_INTACT_BIT   2

// ****************************************************************
// Interrupt bits
// ****************************************************************
`define IRQ_EVENT_BIT     0
`define IRQ_OVERRUN_BIT   1
`define IRQ_OVERFLOW_BIT  2
`define IRQ_BITS          3

`endif

// [overflow_event_pkg.sv]
// Types shared by the overflow event block and its users
package overflow_event_pkg;

  typedef enum logic [2:0] {
    FILTER_INCOMPLETE,
    FILTER_DROPPED,
    FILTER_INCOMPLETE_OR_DROPPED,
    FILTER_CORRECT,
    FILTER_INCOMPLETE_OR_CORRECT,
    FILTER_DROPPED_OR_CORRECT,
    FILTER_ALL,
    FILTER_NONE
  } filter_e;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_PASS,
    FR_CUT,
    FR_DROP
  } frame_state_e;

  typedef struct packed {
    logic        valid;
    logic [63:0] data;
    logic [31:0] stamp;
  } event_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        last;
    logic        truncated;
  } dma_s;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avs_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avs_rsp_s;

  typedef struct packed {
    logic         frame_start;
    logic         frame_end;
    logic [15:0]  frame_number;
    logic         data_valid;
    logic [31:0]  data;
  } cam_s;

  typedef struct packed {
    filter_e      filter;
    logic [7:0]   enter_level;
    logic [7:0]   exit_level;
    logic         overflow;
    frame_state_e frame;
    logic [15:0]  frame_number;
    logic [31:0]  stamp_count;
    logic [31:0]  frame_stamp;
    logic [2:0]   irq_status;
    logic [2:0]   irq_mask;
    logic         irq;
    event_s       event_out;
    logic [63:0]  last_packet;
    dma_s         dma;
    avs_rsp_s     rsp;
  } state_s;

endpackage

// [event_host.sv]
// Host model that takes event packets, with a stall for overrun tests
`timescale 1ns/10ps
`default_nettype none

module event_host (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire overflow_event_pkg::event_s event_out,
  input  wire logic                       stall,
  output logic                            event_ready
);
  import overflow_event_pkg::*;
  // ****
  // Acceptance
  // ****
  // Stall keeps the slot full, so a second event has nowhere to go
  always_ff @(posedge core_clk) begin
    event_ready <= rst_n && !stall;
  end
endmodule

`default_nettype wire

// [fer_props.sv]
// Concurrent checks on the overflow event reporter ports
`timescale 1ns/10ps
`default_nettype none

module fer_props (
  input wire logic                         core_clk,
  input wire logic                         rst_n,
  input wire overflow_event_pkg::avs_req_s avs_req,
  input wire overflow_event_pkg::avs_rsp_s avs_rsp,
  input wire overflow_event_pkg::cam_s     cam,
  input wire overflow_event_pkg::dma_s     dma_out,
  input wire overflow_event_pkg::event_s   event_out,
  input wire logic                         event_ready,
  input wire logic                         overflow_active
);
  import overflow_event_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Sequences
  // ****
  sequence s_req_wait;
    (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
  endsequence
  sequence s_ev_held;
    event_out.valid && !event_ready;
  endsequence
  // ****
  // Event packet
  // ****
  a_event_rsvd:
    assert property (event_out.valid |-> event_out.data[31:16] == 16'h0
      && event_out.data[63:35] == 29'h0)
    else $error("reserved packet bits not zero");
  a_flags_excl:
    assert property (event_out.valid |->
      !(event_out.data[32] && event_out.data[33]))
    else $error("truncated and lost both set");
  a_flag_onehot:
    assert property (event_out.valid |-> $onehot(event_out.data[34:32]))
    else $error("event mask not a single kind");
  a_event_hold:
    assert property (s_ev_held |=> event_out.valid
      && $stable(event_out.data) && $stable(event_out.stamp))
    else $error("event changed before acceptance");
  a_event_cause:
    assert property ($rose(event_out.valid) |-> $past(cam.frame_end))
    else $error("event without a frame end");
  // ****
  // Data path and bus
  // ****
  a_drop_no_dma:
    assert property (overflow_active && $past(overflow_active)
      |-> !dma_out.valid)
    else $error("beat forwarded in overflow");
  a_trunc_zero:
    assert property (dma_out.valid && dma_out.truncated
      |-> dma_out.last && dma_out.data == 32'h0)
    else $error("cut closing beat malformed");
  a_wait_one:
    assert property (s_req_wait |=> !avs_rsp.waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse:
    assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule

bind frame_overflow_event_reporter fer_props u_props (
  .core_clk(core_clk), .rst_n(rst_n), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .cam(cam), .dma_out(dma_out),
  .event_out(event_out), .event_ready(event_ready),
  .overflow_active(overflow_active));

`default_nettype wire

// [tb.sv]
// Testbench for the frame overflow event reporter
`timescale 1ns/10ps
`default_nettype none
`include "overflow_event_defines.svh"

module tb;
  import overflow_event_pkg::*;
  logic        core_clk, rst_n, stall, event_ready, overflow_active, irq;
  avs_req_s    avs_req;
  avs_rsp_s    avs_rsp;
  cam_s        cam;
  logic [7:0]  occ;
  dma_s        dma_out;
  event_s      event_out;
  logic [31:0] rdat, s0, st_cyc, ev_off, off0;
  logic [31:0] dsum = '0;
  logic [63:0] ev_data, pkt;
  logic [15:0] num;
  int          fails, n_checks, n_dma, n_trunc, n_ev, cyc, e0, d0, t0;
  int          n_last, l0;
  // Event presence per kind (cut, lost, intact), one bit per filter
  logic [7:0]  pres [3] = '{8'h55, 8'h66, 8'h78};
  // Sum of beats forwarded per kind (cut, lost, intact)
  logic [31:0] dexp [3] = '{32'ha1, 32'h0, 32'h153};

  frame_overflow_event_reporter u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_req(avs_req), .avs_rsp(avs_rsp), .cam(cam),
    .buffer_occupancy(occ), .dma_out(dma_out), .event_out(event_out),
    .event_ready(event_ready), .overflow_active(overflow_active), .irq(irq));
  event_host u_host (.core_clk(core_clk), .rst_n(rst_n),
    .event_out(event_out), .stall(stall), .event_ready(event_ready));

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic rd, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_req <= '{a, rd, !rd, d};
    do begin
      @(posedge core_clk);
    end while (avs_rsp.waitrequest !== 1'b0);
    rdat = avs_rsp.readdata;
    avs_req <= '0;
  endtask
  // Kind 0 is cut mid-frame, 1 starts in overflow, 2 runs intact
  task automatic frame(input int k);
    @(posedge core_clk);
    occ <= (k == 1) ? 8'hc8 : 8'h00;
    repeat (2) @(posedge core_clk);
    cam <= '{1'b1, 1'b0, num, 1'b0, 32'h0};
    @(posedge core_clk);
    cam <= '{1'b0, 1'b0, num, 1'b1, 32'ha1};
    @(posedge core_clk);
    cam <= '{1'b0, k == 2, num, 1'b1, 32'hb2};
    if (k == 0) occ <= 8'hc8;
    @(posedge core_clk);
    cam <= '{1'b0, k != 2, num, 1'b0, 32'h0};
    @(posedge core_clk);
    cam <= '0;
    occ <= 8'h00;
    repeat (5) @(posedge core_clk);
  endtask

  // ****
  // Clock, monitor, timeout
  // ****
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cam.frame_start === 1'b1) st_cyc = cyc;
    if (dma_out.valid === 1'b1) begin
      n_dma++;
      n_trunc += dma_out.truncated;
      n_last += dma_out.last;
      dsum = dsum + dma_out.data;
    end
    if (event_out.valid === 1'b1 && event_ready === 1'b1) begin
      // Start cycle minus stamp must stay the same for every frame
      ev_off = st_cyc - event_out.stamp;
      if (n_ev == 0) off0 = ev_off;
      n_ev++;
      ev_data = event_out.data;
    end
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end

  // ****
  // Tests
  // ****
  initial begin
    rst_n = 1'b0;
    stall = 1'b0;
    occ = 8'h00;
    avs_req = '0;
    cam = '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b1, `OFS_CTRL, 32'h0);
    chk(rdat, 32'h2);
    bus(1'b1, `OFS_ENTER_LEVEL, 32'h0);
    chk(rdat, 32'hc7);
    bus(1'b1, `OFS_EXIT_LEVEL, 32'h0);
    chk(rdat, 32'h64);
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, 5'h02, 32'h0);
    chk(rdat, 32'h0);
    $display("reset test done");
    // Start near the top so the number wraps inside the loop
    num = 16'hfffe;
    for (int f = 0; f < 8; f++) begin
      bus(1'b0, `OFS_CTRL, 32'(f));
      for (int k = 0; k < 3; k++) begin
        e0 = n_ev;
        d0 = n_dma;
        t0 = n_trunc;
        s0 = dsum;
        l0 = n_last;
        frame(k);
        pkt = {16'h0, 16'(1 << k), 16'h0, num};
        chk(n_ev - e0, pres[k][f]);
        chk(n_dma - d0, (k == 1) ? 64'h0 : 64'h2);
        chk(n_trunc - t0, k == 0);
        chk(dsum - s0, dexp[k]);
        chk(n_last - l0, k != 1);
        if (pres[k][f]) begin
          chk(ev_data, pkt);
          chk(ev_off, off0);
        end
        num++;
      end
      $display("filter %0d test done", f);
    end
    bus(1'b0, `OFS_CTRL, 32'h6);
    num = 16'h00a5;
    frame(2);
    bus(1'b1, `OFS_LAST_LO, 32'h0);
    chk(rdat, 32'h00a5);
    bus(1'b1, `OFS_LAST_HI, 32'h0);
    chk(rdat, 32'h4);
    $display("packet test done");
    stall <= 1'b1;
    num = 16'h1234;
    frame(2);
    num = 16'h5678;
    frame(2);
    @(posedge core_clk);
    chk(event_out.valid, 1'b1);
    chk(event_out.data, 64'h0000_0004_0000_1234);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h0);
    chk(rdat, 32'h7);
    stall <= 1'b0;
    bus(1'b0, `OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    bus(1'b0, `OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1);
    bus(1'b0, `OFS_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h0);
    chk(rdat, 32'h0);
    $display("irq test done");
    // Levels are exclusive: sitting on a threshold changes nothing
    bus(1'b0, `OFS_ENTER_LEVEL, 32'h10);
    bus(1'b0, `OFS_EXIT_LEVEL, 32'h08);
    occ <= 8'h10;
    bus(1'b1, `OFS_STATE, 32'h0);
    chk(rdat, 32'h0);
    occ <= 8'h11;
    bus(1'b1, `OFS_STATE, 32'h0);
    chk(rdat, 32'h1);
    chk(overflow_active, 1'b1);
    occ <= 8'h08;
    bus(1'b1, `OFS_STATE, 32'h0);
    chk(rdat, 32'h1);
    occ <= 8'h07;
    bus(1'b1, `OFS_STATE, 32'h0);
    chk(rdat, 32'h0);
    chk(overflow_active, 1'b0);
    $display("threshold test done");
    wrap_up();
  end
endmodule

`default_nettype wire
